/* acrt_transfer.sv */
// Decoder and executor for accumulator to peripheral register transfers.
`timescale 1ns/100ps
`default_nettype none
module acrt_transfer (
  // Clock and reset.
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  // Instruction from the sequencer, same clock domain.
  input  wire acrt_pkg::acrt_instr_t instr,
  // Destination registers.
  output var  logic [7:0]            timer_one_reload_reg,
  output var  logic [3:0]            interrupt_control_first,
  output var  logic [3:0]            interrupt_control_second,
  output var  logic [3:0]            timer_control_first,
  // Status toward the sequencer.
  output var  acrt_pkg::acrt_status_t status
);

  // Timing of one transfer. A word is taken at the rising edge of mclk at
  // which instr.valid is high and the opcode matches one of the four codes.
  // The destination register and the hit pulse change right after that
  // edge, so every transfer is one word long and ends in one machine cycle.
  // Words may follow each other on every cycle in any order; nothing here
  // stalls the sequencer. A word that is invalid, or whose opcode matches
  // none of the four codes, leaves every register as it was and gives no hit.
  // The carry flag and the skip of the next word are never requested, so
  // the sequencer may treat these transfers like any plain move.

  // Reset synchroniser stages; only the second stage is used by logic.
  logic rst_meta_n;
  logic rst_n;

  // Decoded one-hot strobes for the four transfer instructions.
  // They are read only by the destination registers, the status flop and
  // the checks below.
  logic load_reload_one_from_b_and_acc;
  logic load_int_ctrl_first_from_acc;
  logic load_int_ctrl_second_from_acc;
  logic load_timer_ctrl_first_from_acc;

  // Release of reset passes two flip-flops so it leaves cleanly on mclk.
  // Assertion needs no clock: both stages clear at once and the outputs
  // follow. Only the release is timed, and it reaches the logic at the
  // second rising edge, so a word may be taken from the third edge on.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // Opcode decode; each strobe requires a valid instruction word.
  // The whole ten-bit opcode is compared, so a word that differs in any bit
  // is refused. The four codes differ from each other, so at most one
  // strobe is high in any cycle.
  assign load_reload_one_from_b_and_acc =
    instr.valid && (instr.opcode == acrt_pkg::OP_LOAD_RELOAD_ONE);
  assign load_int_ctrl_first_from_acc =
    instr.valid && (instr.opcode == acrt_pkg::OP_LOAD_INT_CTRL_FIRST);
  assign load_int_ctrl_second_from_acc =
    instr.valid && (instr.opcode == acrt_pkg::OP_LOAD_INT_CTRL_SECOND);
  assign load_timer_ctrl_first_from_acc =
    instr.valid && (instr.opcode == acrt_pkg::OP_LOAD_TIMER_CTRL_FIRST);

  // Reload register: B to the high nibble, accumulator to the low nibble.
  // It keeps its value until the next reload load or a reset; the timer
  // that counts from it lies outside this block.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_one_reload_reg <= acrt_pkg::RELOAD_RST;
    end else if (load_reload_one_from_b_and_acc) begin
      timer_one_reload_reg <= {instr.reg_b, instr.acc};
    end
  end

  // First interrupt control register takes the accumulator.
  // It keeps its value until the next load of this register or a reset.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_control_first <= acrt_pkg::NIBBLE_RST;
    end else if (load_int_ctrl_first_from_acc) begin
      interrupt_control_first <= instr.acc;
    end
  end

  // Second interrupt control register takes the accumulator.
  // It keeps its value until the next load of this register or a reset.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_control_second <= acrt_pkg::NIBBLE_RST;
    end else if (load_int_ctrl_second_from_acc) begin
      interrupt_control_second <= instr.acc;
    end
  end

  // First timer control register takes the accumulator.
  // It keeps its value until the next load of this register or a reset.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_first <= acrt_pkg::NIBBLE_RST;
    end else if (load_timer_ctrl_first_from_acc) begin
      timer_control_first <= instr.acc;
    end
  end

  // Status: hit marks a one-cycle execution; carry and skip stay low.
  // Hit stands for exactly one cycle per taken word and is low otherwise,
  // so the sequencer can count executed transfers from it directly.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status.hit      <= load_reload_one_from_b_and_acc | load_int_ctrl_first_from_acc |
                         load_int_ctrl_second_from_acc | load_timer_ctrl_first_from_acc;
      status.carry_we <= 1'b0;
      status.skip     <= 1'b0;
    end
  end

  // Checks on the transfers. They are held off while the internal reset
  // copy is low, so the history that $past and $stable see at the first
  // edges after release is always the cleared state.

  // The reload register must show B over A one cycle after its instruction.
  AST_RELOAD: assert property (@(posedge mclk) disable iff (!rst_n)
    load_reload_one_from_b_and_acc |=>
      timer_one_reload_reg == {$past(instr.reg_b), $past(instr.acc)})
    else $error("Reload register not loaded from B and A.");

  // Without its instruction the reload register must not move.
  AST_HOLD_RELOAD: assert property (@(posedge mclk) disable iff (!rst_n)
    !load_reload_one_from_b_and_acc |=> $stable(timer_one_reload_reg))
    else $error("Reload register changed without its instruction.");

  // The first interrupt control register takes A one cycle later.
  AST_INT_FIRST: assert property (@(posedge mclk) disable iff (!rst_n)
    load_int_ctrl_first_from_acc |=> interrupt_control_first == $past(instr.acc))
    else $error("First interrupt control not loaded.");

  // Without its instruction the first interrupt control must not move.
  AST_HOLD_INT_FIRST: assert property (@(posedge mclk) disable iff (!rst_n)
    !load_int_ctrl_first_from_acc |=> $stable(interrupt_control_first))
    else $error("First interrupt control changed without its instruction.");

  // The second interrupt control register takes A one cycle later.
  AST_INT_SECOND: assert property (@(posedge mclk) disable iff (!rst_n)
    load_int_ctrl_second_from_acc |=> interrupt_control_second == $past(instr.acc))
    else $error("Second interrupt control not loaded.");

  // Without its instruction the second interrupt control must not move.
  AST_HOLD_INT_SECOND: assert property (@(posedge mclk) disable iff (!rst_n)
    !load_int_ctrl_second_from_acc |=> $stable(interrupt_control_second))
    else $error("Second interrupt control changed without its instruction.");

  // The first timer control register takes A one cycle later.
  AST_TIMER_FIRST: assert property (@(posedge mclk) disable iff (!rst_n)
    load_timer_ctrl_first_from_acc |=> timer_control_first == $past(instr.acc))
    else $error("Timer control not loaded.");

  // Without its instruction the timer control register must not move.
  AST_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !load_timer_ctrl_first_from_acc |=> $stable(timer_control_first))
    else $error("Timer control changed without its instruction.");

  // A first interrupt control load finishes in one cycle and touches neither carry nor skip.
  AST_ONE_CYCLE: assert property (@(posedge mclk) disable iff (!rst_n)
    (instr.valid && instr.opcode == acrt_pkg::OP_LOAD_INT_CTRL_FIRST) |=>
      status.hit && !status.skip && !status.carry_we)
    else $error("Transfer did not finish in one cycle cleanly.");

  // Carry write and skip are never requested by any of these transfers.
  AST_NO_SKIP: assert property (@(posedge mclk) disable iff (!rst_n)
    !status.skip && !status.carry_we)
    else $error("Transfer touched carry or skip.");

  // No valid word means no hit in the next cycle.
  AST_NO_FALSE_HIT: assert property (@(posedge mclk) disable iff (!rst_n)
    !instr.valid |=> !status.hit)
    else $error("Hit without a valid instruction.");

  // Every decoded transfer must report its hit in the very next cycle.
  AST_HIT_ANY: assert property (@(posedge mclk) disable iff (!rst_n)
    (load_reload_one_from_b_and_acc || load_int_ctrl_first_from_acc ||
     load_int_ctrl_second_from_acc || load_timer_ctrl_first_from_acc) |=> status.hit)
    else $error("Decoded transfer gave no hit.");

  // A valid word with none of the four opcodes must not raise the hit.
  AST_REFUSED: assert property (@(posedge mclk) disable iff (!rst_n)
    (instr.valid && instr.opcode != acrt_pkg::OP_LOAD_RELOAD_ONE &&
     instr.opcode != acrt_pkg::OP_LOAD_INT_CTRL_FIRST &&
     instr.opcode != acrt_pkg::OP_LOAD_INT_CTRL_SECOND &&
     instr.opcode != acrt_pkg::OP_LOAD_TIMER_CTRL_FIRST) |=> !status.hit)
    else $error("Unknown opcode gave a hit.");

  // Main scenarios: the reload and timer transfers alone, transfers back to back, and a
  // refused word.
  // A reload load on its own.
  COV_RELOAD: cover property (@(posedge mclk) disable iff (!rst_n)
    load_reload_one_from_b_and_acc);
  // Second then first interrupt control load in consecutive cycles.
  COV_INT_BOTH: cover property (@(posedge mclk) disable iff (!rst_n)
    load_int_ctrl_second_from_acc ##1 load_int_ctrl_first_from_acc);
  // A timer control load on its own.
  COV_TIMER: cover property (@(posedge mclk) disable iff (!rst_n)
    load_timer_ctrl_first_from_acc);
  // A valid word that none of the four opcodes matches.
  COV_REFUSED: cover property (@(posedge mclk) disable iff (!rst_n)
    instr.valid && !load_reload_one_from_b_and_acc && !load_int_ctrl_first_from_acc &&
      !load_int_ctrl_second_from_acc && !load_timer_ctrl_first_from_acc);
  // Two reload loads in consecutive cycles.
  COV_RELOAD_TWICE: cover property (@(posedge mclk) disable iff (!rst_n)
    load_reload_one_from_b_and_acc ##1 load_reload_one_from_b_and_acc);

endmodule
`default_nettype wire

/* acrt_pkg.sv */
// Package with opcodes, carriers and reset values for the accumulator transfer decoder.
package acrt_pkg;

  // Width of one instruction word.
  localparam int unsigned INSTR_W = 10;

  // Opcode that loads the first interrupt control register from the accumulator.
  localparam logic [9:0] OP_LOAD_INT_CTRL_FIRST = 10'h03F;
  // Opcode that loads the first timer control register from the accumulator.
  localparam logic [9:0] OP_LOAD_TIMER_CTRL_FIRST = 10'h20E;
  // Opcode of the reload load; this value is a free choice of the block.
  localparam logic [9:0] OP_LOAD_RELOAD_ONE = 10'h23F;
  // Opcode of the second interrupt control load; also a free choice.
  localparam logic [9:0] OP_LOAD_INT_CTRL_SECOND = 10'h03E;

  // Reset values of the destination registers.
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [3:0] NIBBLE_RST = 4'h0;

  // Instruction presented for execution with its source operands.
  typedef struct packed {
    logic       valid;
    logic [9:0] opcode;
    logic [3:0] acc;
    logic [3:0] reg_b;
  } acrt_instr_t;

  // Result flags reported back to the sequencer.
  typedef struct packed {
    logic hit;
    logic carry_we;
    logic skip;
  } acrt_status_t;

endpackage

/* acrt_seq_model.sv */
// Sequencer model that presents instructions and operands to the decoder.
`timescale 1ns/100ps
`default_nettype none
module acrt_seq_model (
  // Clock.
  input  wire logic                  mclk,
  // Request from the bench.
  input  wire logic                  go,
  input  wire logic [9:0]            op,
  input  wire logic [3:0]            a,
  input  wire logic [3:0]            b,
  // Instruction toward the decoder.
  output var  acrt_pkg::acrt_instr_t instr
);
  acrt_pkg::acrt_instr_t last = '0; // Last issued word.

  // Remembers each issued word so a released bus can show its inverse.
  always @(posedge mclk) begin
    if (go) begin
      last <= instr;
    end
  end

  // Presents the request, or the inverted last word once released.
  always_comb begin
    instr = go ? {1'b1, op, a, b} : {1'b0, ~last[17:0]};
  end
endmodule
`default_nettype wire

/* test_accumulator_register_transfer.sv */
// Testbench for the accumulator transfer decoder.
`timescale 1ns/100ps
`default_nettype none
module test_accumulator_register_transfer;
  logic                   mclk = 1'b0;      // Core clock.
  logic                   reset_n = 1'b0;   // Core reset.
  logic                   go = 1'b0;        // Request to the model.
  logic [9:0]             op = 10'h000;     // Opcode to issue.
  logic [3:0]             a = 4'h0;         // Accumulator value.
  logic [3:0]             b = 4'h0;         // Register B value.
  acrt_pkg::acrt_instr_t  instr;            // Word from the model.
  logic [7:0]             rld;              // Reload register.
  logic [3:0]             icf, ics, tcf;    // Control nibbles.
  acrt_pkg::acrt_status_t st;               // Status flags.
  logic [7:0]             e_rld = 8'h00;    // Expected reload.
  logic [3:0]             e_icf = 4'h0, e_ics = 4'h0, e_tcf = 4'h0; // Expected nibbles.
  logic                   hit_q = 1'b0;     // Expected hit pulse.
  int                     err_count = 0;    // Mismatches.
  int                     comparisons = 0;  // Compares made.
  logic [9:0]             ops [4] = '{acrt_pkg::OP_LOAD_RELOAD_ONE,
    acrt_pkg::OP_LOAD_INT_CTRL_FIRST, acrt_pkg::OP_LOAD_INT_CTRL_SECOND,
    acrt_pkg::OP_LOAD_TIMER_CTRL_FIRST};    // All transfer opcodes.

  acrt_seq_model u_seq (.mclk(mclk), .go(go), .op(op), .a(a), .b(b), .instr(instr));
  acrt_transfer dut_u (.mclk(mclk), .reset_n(reset_n), .instr(instr),
    .timer_one_reload_reg(rld), .interrupt_control_first(icf),
    .interrupt_control_second(ics), .timer_control_first(tcf), .status(st));

  // Free-running 125 MHz clock.
  always #4 mclk = ~mclk;

  // Compares one value and reports a mismatch.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Checks every destination and the status flags.
  task automatic chk_all(input logic hit);
    chk(rld, e_rld);
    chk({4'h0, icf}, {4'h0, e_icf});
    chk({4'h0, ics}, {4'h0, e_ics});
    chk({4'h0, tcf}, {4'h0, e_tcf});
    chk({5'h00, st}, {5'h00, hit, 2'h0});
  endtask

  // Checks the last cycle, then drives one word for the next cycle.
  task automatic step(input logic v, input logic [9:0] o, input logic [3:0] av,
                      input logic [3:0] bv);
    @(negedge mclk);
    chk_all(hit_q);
    go = v;
    op = o;
    a = av;
    b = bv;
    hit_q = v;
    if (v) begin
      case (o)
        acrt_pkg::OP_LOAD_RELOAD_ONE: e_rld = {bv, av};
        acrt_pkg::OP_LOAD_INT_CTRL_FIRST: e_icf = av;
        acrt_pkg::OP_LOAD_INT_CTRL_SECOND: e_ics = av;
        acrt_pkg::OP_LOAD_TIMER_CTRL_FIRST: e_tcf = av;
        default: hit_q = 1'b0;
      endcase
    end
  endtask

  // Each opcode alone, each followed by an idle cycle.
  task automatic t_each();
    for (int i = 0; i < 4; i++) begin
      step(1'b1, ops[i], 4'(i + 9), 4'(6 - i));
      step(1'b0, ops[i], 4'h0, 4'h0);
    end
  endtask

  // All opcodes back to back with boundary operands.
  task automatic t_back();
    for (int i = 3; i >= 0; i--) begin
      step(1'b1, ops[i], 4'hF, 4'h0);
    end
    step(1'b1, ops[0], 4'h0, 4'hF);
    step(1'b0, 10'h000, 4'h0, 4'h0);
  endtask

  // Near-miss opcodes must leave every register alone.
  task automatic t_refuse();
    step(1'b1, 10'h13F, 4'h3, 4'h3);
    step(1'b1, 10'h20F, 4'h3, 4'h3);
    step(1'b1, 10'h03C, 4'h3, 4'h3);
    step(1'b0, 10'h000, 4'h0, 4'h0);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (16) @(negedge mclk);
    chk_all(1'b0);
    reset_n = 1'b1;
    repeat (3) @(negedge mclk);
    t_each();
    t_back();
    t_refuse();
    step(1'b0, 10'h000, 4'h0, 4'h0);
    test_done();
  end

  // Watchdog: the run needs under 100 cycles, so 1000 means a hang.
  initial begin
    #8000;
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire
